// ===== gdcl_assertions.sv
// Checker for the gate drive control logic
`timescale 1ns/100ps
module gdcl_checker
  import gdcl_pkg::*;
#(
  parameter int unsigned DT_WIDTH = GDCL_DT_WIDTH,
  parameter int unsigned ESCALATE_CYCLES = GDCL_ESCALATE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Inputs
  input wire logic chan_a_input,
  input wire logic chan_b_input,
  input wire logic pwm_input,
  input wire logic drive_disable_in,
  input wire logic pwm_mode_sel,
  input wire logic dual_mode_strap,
  input wire logic [DT_WIDTH-1:0] dead_time_config,
  input wire logic chan_a_over_trigger,
  input wire logic chan_a_below_release,
  input wire logic chan_b_over_trigger,
  input wire logic chan_b_below_release,
  // Outputs
  input wire logic chan_a_gate_out,
  input wire logic chan_b_gate_out,
  input wire logic chan_a_weak_low,
  input wire logic chan_b_weak_low,
  input wire logic chan_a_thermal_fault,
  input wire logic chan_b_thermal_fault
);
  int cnt_a;
  int low_a;
  wire logic paired = !dual_mode_strap || pwm_mode_sel;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Fault and low-time counters
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_a <= 0;
      // Channel A counts as long off after reset
      low_a <= 1000;
    end else begin
      cnt_a <= chan_a_thermal_fault ? cnt_a + 1 : 0;
      low_a <= chan_a_gate_out ? 0 : low_a + 1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_NO_OVERLAP: assert property (paired |-> !(chan_a_gate_out && chan_b_gate_out))
    else $error("both gates on");
  AST_DIS_OFF: assert property (drive_disable_in [*3] |=> !chan_a_gate_out && !chan_b_gate_out)
    else $error("disable ignored");
  AST_FAULT_A: assert property ((chan_a_over_trigger && !chan_a_below_release) [*3] |-> ##[1:2] chan_a_thermal_fault)
    else $error("no fault on overheat");
  AST_STRONG_LOW: assert property (chan_a_thermal_fault && $past(chan_a_thermal_fault) |-> !chan_a_gate_out)
    else $error("gate on in fault");
  AST_WEAK_EARLY: assert property (chan_a_weak_low |-> cnt_a >= ESCALATE_CYCLES - 1)
    else $error("weak low too early");
  AST_WEAK_LATE: assert property (cnt_a >= ESCALATE_CYCLES + 4 |-> chan_a_weak_low)
    else $error("weak low missing");
  AST_WEAK_HELD: assert property (chan_a_weak_low |-> $past(chan_a_thermal_fault) && !chan_a_gate_out)
    else $error("weak low outside fault");
  AST_DUAL_FOLLOW: assert property (!paired && !$past(drive_disable_in, 3) && !chan_a_thermal_fault
    && !$past(chan_a_thermal_fault) && !$past(chan_a_thermal_fault, 2) && !$past(chan_a_over_trigger, 3)
    |-> chan_a_gate_out == $past(chan_a_input, 3)) else $error("dual output not following");
  AST_FALL_NOW: assert property (!$past(chan_a_input, 3) |-> !chan_a_gate_out)
    else $error("fall delayed");
  AST_DEAD_TIME: assert property (paired && $rose(chan_b_gate_out) |-> low_a + 1 >= int'(dead_time_config))
    else $error("dead time short");
  cover property (chan_a_weak_low);
  cover property (paired && $rose(chan_b_gate_out));
  cover property (drive_disable_in [*3]);
endmodule : gdcl_checker

bind gdcl_gate_drive_control gdcl_checker #(.DT_WIDTH(DT_WIDTH), .ESCALATE_CYCLES(ESCALATE_CYCLES)) u_chk (
  .clock(clock), .reset_n(reset_n), .chan_a_input(chan_a_input), .chan_b_input(chan_b_input),
  .pwm_input(pwm_input), .drive_disable_in(drive_disable_in), .pwm_mode_sel(pwm_mode_sel),
  .dual_mode_strap(dual_mode_strap), .dead_time_config(dead_time_config),
  .chan_a_over_trigger(chan_a_over_trigger), .chan_a_below_release(chan_a_below_release),
  .chan_b_over_trigger(chan_b_over_trigger), .chan_b_below_release(chan_b_below_release),
  .chan_a_gate_out(chan_a_gate_out), .chan_b_gate_out(chan_b_gate_out), .chan_a_weak_low(chan_a_weak_low),
  .chan_b_weak_low(chan_b_weak_low), .chan_a_thermal_fault(chan_a_thermal_fault),
  .chan_b_thermal_fault(chan_b_thermal_fault));

// ===== gdcl_ctrl_model.sv
// Controller model driving the request pins
`timescale 1ns/100ps
module gdcl_ctrl_model (
  // Requests
  input wire logic a_req,
  input wire logic b_req,
  input wire logic dis_req,
  input wire logic dual,
  // Pins
  output logic chan_a_input,
  output logic chan_b_input,
  output logic drive_disable_in
);
  assign chan_a_input = a_req;
  assign chan_b_input = b_req && !(dual && a_req);
  assign drive_disable_in = dis_req;
endmodule : gdcl_ctrl_model

// ===== gdcl_gate_drive_control.sv
// Gate drive control logic: dead time, overlap, disable and thermal handling
//
// Operation
// - Each channel's temperature watched independently, continuously
// - Over-trigger raises fault and drives strong low
// - Still hot after 1 ms: weak low
// - Weak low held while not below release
// - Cooled below release: resume following inputs
// - Paired mode never drives both outputs on
// - Dead time only before rising edges
// - Disable input forces both outputs off on the third clock edge, after its two-flop synchroniser
// - PWM mode: high from channel A input, low from its complement
// - Dual mode strap selects independent dual drivers outside PWM mode
// - Input fall starts opposite channel's dead time
// - Dead time is longer of programmed, input gap
// - Both inputs high outside dual and PWM modes: both outputs low at once
`timescale 1ns/100ps
module gdcl_gate_drive_control
  import gdcl_pkg::*;
#(
  parameter int unsigned DT_WIDTH = GDCL_DT_WIDTH,
  parameter int unsigned ESCALATE_CYCLES = GDCL_ESCALATE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Controller inputs (pins)
  input wire logic chan_a_input,
  input wire logic chan_b_input,
  input wire logic pwm_input,
  input wire logic drive_disable_in,
  // Static configuration
  input wire logic pwm_mode_sel,
  input wire logic dual_mode_strap,
  input wire logic [DT_WIDTH-1:0] dead_time_config,
  // Temperature indications per channel
  input wire logic chan_a_over_trigger,
  input wire logic chan_a_below_release,
  input wire logic chan_b_over_trigger,
  input wire logic chan_b_below_release,
  // Gate drive commands
  output logic chan_a_gate_out,
  output logic chan_b_gate_out,
  output logic chan_a_weak_low,
  output logic chan_b_weak_low,
  // Thermal status
  output logic chan_a_thermal_fault,
  output logic chan_b_thermal_fault
);

  initial begin
    if (DT_WIDTH < 1 || DT_WIDTH > 16) begin
      $error("gdcl_gate_drive_control: DT_WIDTH out of range");
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] th_a_s1;
    logic [1:0] th_a_s2;
    logic [1:0] th_b_s1;
    logic [1:0] th_b_s2;
    logic [1:0] dis_s;
    logic [1:0] in_prev;
    logic [DT_WIDTH-1:0] dt_cfg;
    logic cfg_dual;
    logic cfg_pwm;
    logic cfg_loaded;
    logic [DT_WIDTH-1:0] cnt_a;
    logic [DT_WIDTH-1:0] cnt_b;
    logic out_a;
    logic out_b;
    logic weak_a;
    logic weak_b;
  } gdcl_state_t;

  gdcl_state_t state_reg;
  gdcl_state_t state_next;

  logic fault_a;
  logic fault_b;
  gdcl_drive_t mode_a;
  gdcl_drive_t mode_b;

  // ----------------------------------------
  // Thermal sequencers
  // ----------------------------------------
  gdcl_thermal #(
    .ESCALATE_CYCLES(ESCALATE_CYCLES)
  ) u_therm_a (
    .clock(clock),
    .reset_n(reset_n),
    .over_trigger(state_reg.th_a_s2[0]),
    .below_release(state_reg.th_a_s2[1]),
    .fault(fault_a),
    .drive_mode(mode_a)
  );

  gdcl_thermal #(
    .ESCALATE_CYCLES(ESCALATE_CYCLES)
  ) u_therm_b (
    .clock(clock),
    .reset_n(reset_n),
    .over_trigger(state_reg.th_b_s2[0]),
    .below_release(state_reg.th_b_s2[1]),
    .fault(fault_b),
    .drive_mode(mode_b)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic req_a;
    logic req_b;
    logic fall_a;
    logic fall_b;
    logic cmd_a;
    logic cmd_b;
    logic dis;
    req_a = 1'b0;
    req_b = 1'b0;
    fall_a = 1'b0;
    fall_b = 1'b0;
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    dis = 1'b0;
    state_next = state_reg;

    // Two-flop synchronisers
    state_next.s1 = {chan_b_input, chan_a_input};
    state_next.s2 = state_reg.s1;
    state_next.th_a_s1 = {chan_a_below_release, chan_a_over_trigger};
    state_next.th_a_s2 = state_reg.th_a_s1;
    state_next.th_b_s1 = {chan_b_below_release, chan_b_over_trigger};
    state_next.th_b_s2 = state_reg.th_b_s1;
    state_next.dis_s = {state_reg.dis_s[0], drive_disable_in};
    dis = state_reg.dis_s[1];

    // Static configuration caught once at reset release
    if (!state_reg.cfg_loaded) begin
      state_next.dt_cfg = dead_time_config;
      state_next.cfg_dual = dual_mode_strap;
      state_next.cfg_pwm = pwm_mode_sel;
      state_next.cfg_loaded = 1'b1;
    end

    // Input selection
    if (state_reg.cfg_pwm) begin
      req_a = state_reg.s2[0];
      req_b = ~state_reg.s2[0];
    end else begin
      req_a = state_reg.s2[0];
      req_b = state_reg.s2[1];
    end
    state_next.in_prev = {req_b, req_a};
    fall_a = state_reg.in_prev[0] & ~req_a;
    fall_b = state_reg.in_prev[1] & ~req_b;

    if (state_reg.cfg_dual && !state_reg.cfg_pwm) begin
      cmd_a = req_a;
      cmd_b = req_b;
      state_next.cnt_a = '0;
      state_next.cnt_b = '0;
    end else begin
      // Dead-time counters run while the opposite side is low
      if (fall_b) begin
        state_next.cnt_a = state_reg.dt_cfg;
      end else if (state_reg.cnt_a != '0 && !req_b) begin
        state_next.cnt_a = state_reg.cnt_a - 1'b1;
      end
      if (fall_a) begin
        state_next.cnt_b = state_reg.dt_cfg;
      end else if (state_reg.cnt_b != '0 && !req_a) begin
        state_next.cnt_b = state_reg.cnt_b - 1'b1;
      end
      // Rise only when own request high, other low, interval expired
      cmd_a = req_a & ~req_b & (state_reg.cnt_a == '0) & ~fall_b;
      cmd_b = req_b & ~req_a & (state_reg.cnt_b == '0) & ~fall_a;
      if (req_a && req_b) begin
        cmd_a = 1'b0;
        cmd_b = 1'b0;
      end
    end

    // Disable and thermal overrides
    if (dis) begin
      cmd_a = 1'b0;
      cmd_b = 1'b0;
    end
    if (mode_a != GDCL_DRV_FOLLOW) begin
      cmd_a = 1'b0;
    end
    if (mode_b != GDCL_DRV_FOLLOW) begin
      cmd_b = 1'b0;
    end

    state_next.out_a = cmd_a;
    state_next.out_b = cmd_b;
    state_next.weak_a = (mode_a == GDCL_DRV_WEAK_LOW);
    state_next.weak_b = (mode_b == GDCL_DRV_WEAK_LOW);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign chan_a_gate_out = state_reg.out_a;
  assign chan_b_gate_out = state_reg.out_b;
  assign chan_a_weak_low = state_reg.weak_a;
  assign chan_b_weak_low = state_reg.weak_b;
  assign chan_a_thermal_fault = fault_a;
  assign chan_b_thermal_fault = fault_b;

endmodule : gdcl_gate_drive_control

// ===== gdcl_pkg.sv
// Package of constants and types for the gate drive control logic
package gdcl_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned GDCL_CLK_HZ = 10000000;
  localparam int unsigned GDCL_ESCALATE_US = 1000;
  localparam int unsigned GDCL_ESCALATE_CYCLES = (GDCL_CLK_HZ / 1000000) * GDCL_ESCALATE_US;
  localparam int unsigned GDCL_DT_WIDTH = 8;
  localparam int unsigned GDCL_ESC_WIDTH = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [GDCL_DT_WIDTH-1:0] GDCL_DT_RESET = 8'h00;
  localparam logic [GDCL_ESC_WIDTH-1:0] GDCL_ESC_RESET = 16'h0000;

  // ----------------------------------------
  // Drive and thermal states
  // ----------------------------------------
  typedef enum logic [1:0] {
    GDCL_DRV_FOLLOW = 2'b00,
    GDCL_DRV_STRONG_LOW = 2'b01,
    GDCL_DRV_WEAK_LOW = 2'b10
  } gdcl_drive_t;

  typedef enum logic [1:0] {
    GDCL_TH_NORMAL = 2'b00,
    GDCL_TH_FAULT = 2'b01,
    GDCL_TH_WEAK = 2'b10
  } gdcl_therm_t;

endpackage : gdcl_pkg

// ===== gdcl_thermal.sv
// Per-channel thermal fault sequencer
`timescale 1ns/100ps
module gdcl_thermal
  import gdcl_pkg::*;
#(
  parameter int unsigned ESCALATE_CYCLES = GDCL_ESCALATE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Synchronised temperature indications
  input wire logic over_trigger,
  input wire logic below_release,
  // Status
  output logic fault,
  output gdcl_drive_t drive_mode
);

  initial begin
    if (ESCALATE_CYCLES < 1 || ESCALATE_CYCLES >= (1 << GDCL_ESC_WIDTH)) begin
      $error("gdcl_thermal: escalation count out of range");
    end
  end

  typedef struct packed {
    gdcl_therm_t st;
    logic [GDCL_ESC_WIDTH-1:0] cnt;
  } gdcl_th_state_t;

  gdcl_th_state_t state_reg;
  gdcl_th_state_t state_next;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.st)
      GDCL_TH_NORMAL: begin
        state_next.cnt = GDCL_ESC_RESET;
        if (over_trigger) begin
          state_next.st = GDCL_TH_FAULT;
        end
      end
      GDCL_TH_FAULT: begin
        if (below_release) begin
          state_next.st = GDCL_TH_NORMAL;
          state_next.cnt = GDCL_ESC_RESET;
        end else if (state_reg.cnt == GDCL_ESC_WIDTH'(ESCALATE_CYCLES - 1)) begin
          state_next.st = GDCL_TH_WEAK;
          state_next.cnt = GDCL_ESC_RESET;
        end else begin
          state_next.cnt = state_reg.cnt + 1'b1;
        end
      end
      GDCL_TH_WEAK: begin
        state_next.cnt = GDCL_ESC_RESET;
        if (below_release) begin
          state_next.st = GDCL_TH_NORMAL;
        end
      end
      default: begin
        state_next.st = GDCL_TH_FAULT;
        state_next.cnt = GDCL_ESC_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{st: GDCL_TH_NORMAL, cnt: GDCL_ESC_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign fault = (state_reg.st != GDCL_TH_NORMAL);
  assign drive_mode = (state_reg.st == GDCL_TH_WEAK) ? GDCL_DRV_WEAK_LOW :
                      (state_reg.st == GDCL_TH_FAULT) ? GDCL_DRV_STRONG_LOW : GDCL_DRV_FOLLOW;

endmodule : gdcl_thermal

// ===== tb_top.sv
// Testbench for the gate drive control logic
`timescale 1ns/100ps
module tb_top;
  import gdcl_pkg::*;
  localparam int ESC = 20;
  logic clock, reset_n, a_req, b_req, dis_req, pwm_sel, dual;
  logic chan_a_input, chan_b_input, drive_disable_in;
  logic a_out, b_out, a_wk, b_wk, a_ft, b_ft;
  logic [7:0] dt;
  logic [1:0] ot, br, f;
  logic [5:0] exp_q[$];
  int bad_count, n_tests, seed, i, r;
  event chk;
  gdcl_ctrl_model u_ctrl (.a_req(a_req), .b_req(b_req), .dis_req(dis_req), .dual(dual),
    .chan_a_input(chan_a_input), .chan_b_input(chan_b_input), .drive_disable_in(drive_disable_in));
  gdcl_gate_drive_control #(.ESCALATE_CYCLES(ESC)) u_dut (.clock(clock), .reset_n(reset_n),
    .chan_a_input(chan_a_input), .chan_b_input(chan_b_input), .pwm_input(1'b0),
    .drive_disable_in(drive_disable_in), .pwm_mode_sel(pwm_sel), .dual_mode_strap(dual),
    .dead_time_config(dt), .chan_a_over_trigger(ot[1]), .chan_a_below_release(br[1]),
    .chan_b_over_trigger(ot[0]), .chan_b_below_release(br[0]), .chan_a_gate_out(a_out),
    .chan_b_gate_out(b_out), .chan_a_weak_low(a_wk), .chan_b_weak_low(b_wk),
    .chan_a_thermal_fault(a_ft), .chan_b_thermal_fault(b_ft));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask : step
  task drv(input logic a, input logic b, input logic d);
    a_req = a;
    b_req = b;
    dis_req = d;
  endtask : drv
  task note(input logic [5:0] e);
    exp_q.push_back(e);
    -> chk;
  endtask : note
  task rst(input logic p, input logic d);
    reset_n = 0;
    pwm_sel = p;
    dual = d;
    drv(0, 0, 0);
    step(3);
    reset_n = 1;
    step(2);
  endtask : rst
  task end_sim;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial forever begin
    @(chk);
    n_tests++;
    if (exp_q.pop_front() !== {a_out, b_out, a_wk, b_wk, a_ft, b_ft}) begin
      bad_count++;
      $display("unexpected at %0t: outputs differ", $time);
    end
  end
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = 37;
    dt = 8'h04;
    ot = 2'h0;
    br = 2'h0;
    rst(0, 0);
    note(6'h00);
    drv(1, 0, 0); step(4); note(6'h20);
    drv(0, 1, 0); step(4); note(6'h00);
    step(8); note(6'h10);
    drv(1, 1, 0); step(4); note(6'h00);
    drv(0, 0, 0); step(12); drv(0, 1, 0); step(4); note(6'h10);
    drv(0, 1, 1); step(4); note(6'h00);
    $display("paired test done");
    rst(0, 1);
    for (i = 0; i < 2; i++) begin
      f = (i == 0) ? 2'h2 : 2'h1;
      drv(f[1], f[0], 0); step(4); note({f, 4'h0});
      ot = f; step(5); note({4'h0, f});
      step(ESC - 6); note({4'h0, f});
      step(12); note({2'h0, f, f});
      ot = 2'h0; step(10); note({2'h0, f, f});
      br = f; step(6); note({f, 4'h0});
      br = 2'h0; ot = f; step(ESC - 4); ot = 2'h0; br = f; step(6);
      br = 2'h0; ot = f; step(ESC - 4); note({4'h0, f});
      ot = 2'h0; br = f; step(6); note({f, 4'h0});
      br = 2'h0;
    end
    for (i = 0; i < 10; i++) begin
      r = $random(seed);
      drv(r[0], r[1], 0); step(4); note({r[0], r[1] & ~r[0], 4'h0});
    end
    $display("thermal and dual test done");
    rst(1, 1);
    drv(1, 0, 0); step(12); note(6'h20);
    drv(0, 0, 0); step(4); note(6'h00);
    step(8); note(6'h10);
    $display("pwm test done");
    step(1);
    end_sim();
  end
endmodule : tb_top
